// file: design/stt_pkg.sv
package stt_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the APB word grid)
	// ----------------------------------------------------------------
	localparam logic [7:0] STT_OFS_CTRL = 8'h00;
	localparam logic [7:0] STT_OFS_KEY_FIRST = 8'h04;
	localparam logic [7:0] STT_OFS_KEY_SECOND = 8'h08;
	localparam logic [7:0] STT_OFS_DAT_ONE_TWO = 8'h0c;
	localparam logic [7:0] STT_OFS_DAT_THREE_FOUR = 8'h10;
	localparam logic [7:0] STT_OFS_DAT_FIVE_SIX = 8'h14;
	localparam logic [7:0] STT_OFS_BAUD_RELOAD = 8'h18;
	localparam logic [7:0] STT_OFS_BAUD_CONFIG = 8'h1c;

	// ----------------------------------------------------------------
	// Key values and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] STT_KEY_FIRST_VALUE = 16'h0007;
	localparam logic [15:0] STT_KEY_SECOND_VALUE = 16'h00b9;
	localparam logic [15:0] STT_DATA_RESET = 16'h0000;
	localparam logic [15:0] STT_RELOAD_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Control and baud config register field positions
	// ----------------------------------------------------------------
	localparam int STT_CTRL_EN_BIT = 0;
	localparam int STT_CTRL_RST_BIT = 1;
	localparam int STT_CTRL_CNT_LSB = 2;
	localparam int STT_CTRL_CNT_MSB = 4;
	localparam int STT_CTRL_STATE_LSB = 5;
	localparam int STT_CTRL_STATE_MSB = 8;
	localparam int STT_BAUD_EN_BIT = 0;

	// ----------------------------------------------------------------
	// Character framing
	// ----------------------------------------------------------------
	localparam logic [3:0] STT_BIT_START = 4'h0;
	localparam logic [3:0] STT_BIT_PARITY = 4'h9;
	localparam logic [3:0] STT_BIT_LAST = 4'hb;
	localparam logic [2:0] STT_CNT_MAX = 3'h5;
	localparam logic [2:0] STT_CNT_NEED_SECOND = 3'h2;
	localparam logic [2:0] STT_CNT_NEED_THIRD = 3'h4;
	localparam logic STT_LINE_IDLE = 1'b1;
	localparam logic STT_LINE_START = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] count;
		logic en;
	} stt_ctrl_t;

	typedef struct packed {
		logic en;
		logic [15:0] reload;
	} stt_baud_cfg_t;

	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_ARMED = 2'b01,
		KEY_HELD = 2'b10
	} stt_key_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SEND = 2'b10
	} stt_tx_state_t;

endpackage

// file: design/stt_baud_timer.sv
`timescale 1ns/1ps
module stt_baud_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire stt_pkg::stt_baud_cfg_t cfg,
	output logic tick
);
	import stt_pkg::*;

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic at_zero;

	// ----------------------------------------------------------------
	// Down counter, one overflow every reload cycles
	// ----------------------------------------------------------------
	// A reload of 0 or 1 simply ticks every cycle
	assign at_zero = (cnt_q == 16'h0000);
	assign tick = cfg.en & at_zero; // RULE2
	assign cnt_d = !cfg.en ? 16'h0000 :
		at_zero ? ((cfg.reload == 16'h0000) ? 16'h0000 : cfg.reload - 16'h0001) :
		cnt_q - 16'h0001;

	// Counter register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

// file: design/stt_serial_test_tx.sv
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Contract
// RULE1: Nothing is sent before timer setup, keyed enable and loaded data.
// RULE2: Every bit period is one baud timer overflow; reload equals clock over rate.
// RULE3: Control writes outside the key sequence are discarded.
// RULE4: Once enabled, wait until the selected bytes are written, then send.
// RULE5: While sending, control reads show nonzero state bits.
// RULE6: After the last byte, control reads return the written value.
// RULE7: Clearing control bit 0 disables the port.
// RULE8: Each byte is start, eight data, parity, two stop bits.
// RULE9: Control write counts only between key 0x0007 and key 0x00b9.
// RULE10: Control bits 4:2 select one to six bytes.
// RULE11: Writing control bit 1 resets the interface; control then reads zero.
// RULE12: Each data register holds two bytes, earlier byte in low half.
// RULE13: Bytes go LSB first; line idles high between characters and when off.
module stt_serial_test_tx (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic serial_test_port
);
	import stt_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	stt_ctrl_t ctrl_q;
	stt_ctrl_t held_q;
	stt_key_state_t key_q;
	stt_tx_state_t tx_q;
	stt_baud_cfg_t baud_q;
	logic [15:0] dat_q [3];
	logic [2:0] loaded_q;
	logic [2:0] byte_idx_q;
	logic [3:0] bit_idx_q;
	logic line_q;
	logic baud_tick;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic wr_en;
	logic hit_ctrl;
	logic hit_key_first;
	logic hit_key_second;
	logic hit_baud_reload;
	logic hit_baud_config;
	logic [2:0] hit_dat;
	logic mapped;
	logic key_first_ok;
	logic key_second_ok;
	logic commit;
	logic commit_reset;
	logic held_q_rst_q;

	assign hit_ctrl = (paddr == STT_OFS_CTRL);
	assign hit_key_first = (paddr == STT_OFS_KEY_FIRST);
	assign hit_key_second = (paddr == STT_OFS_KEY_SECOND);
	assign hit_dat[0] = (paddr == STT_OFS_DAT_ONE_TWO);
	assign hit_dat[1] = (paddr == STT_OFS_DAT_THREE_FOUR);
	assign hit_dat[2] = (paddr == STT_OFS_DAT_FIVE_SIX);
	assign hit_baud_reload = (paddr == STT_OFS_BAUD_RELOAD);
	assign hit_baud_config = (paddr == STT_OFS_BAUD_CONFIG);
	assign mapped = hit_ctrl | hit_key_first | hit_key_second | (|hit_dat) |
		hit_baud_reload | hit_baud_config;
	// Zero wait states; unmapped offsets answer with an error and no effect
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr_en = psel & penable & pwrite & mapped;

	// Key sequence qualifiers
	assign key_first_ok = hit_key_first & (pwdata[15:0] == STT_KEY_FIRST_VALUE);
	assign key_second_ok = hit_key_second & (pwdata[15:0] == STT_KEY_SECOND_VALUE);
	assign commit = wr_en & (key_q == KEY_HELD) & key_second_ok; // RULE9
	assign commit_reset = commit & held_q_rst_q;

	// ----------------------------------------------------------------
	// Transmit sequencing terms
	// ----------------------------------------------------------------
	logic [2:0] need;
	logic data_ready;
	logic busy;
	logic last_byte;
	logic [15:0] cur_word;
	logic [7:0] cur_byte;
	logic [3:0] next_bit;
	logic next_line;
	logic [3:0] state_bits;
	logic [2:0] last_idx;
	logic burst_end;

	// Codes above six bytes are clamped to six
	assign last_idx = (ctrl_q.count > STT_CNT_MAX) ? STT_CNT_MAX : ctrl_q.count; // RULE10
	assign need[0] = 1'b1;
	assign need[1] = (last_idx >= STT_CNT_NEED_SECOND); // RULE4
	assign need[2] = (last_idx >= STT_CNT_NEED_THIRD); // RULE4
	assign data_ready = ((loaded_q & need) == need); // RULE4
	assign busy = (tx_q != TX_IDLE);
	assign last_byte = (byte_idx_q == last_idx);
	assign burst_end = commit | (tx_q == TX_SEND & baud_tick & bit_idx_q == STT_BIT_LAST &
		last_byte);
	// Earlier byte of a pair sits in the low half
	assign cur_word = dat_q[byte_idx_q[2:1]]; // RULE12
	assign cur_byte = byte_idx_q[0] ? cur_word[15:8] : cur_word[7:0]; // RULE12
	assign next_bit = bit_idx_q + 4'h1;
	// Data bits 1..8 LSB first, even parity, then stop bits at idle level
	assign next_line = (next_bit < STT_BIT_PARITY) ? cur_byte[next_bit[2:0] - 3'h1] :
		(next_bit == STT_BIT_PARITY) ? ^cur_byte : STT_LINE_IDLE; // RULE8 RULE13
	assign state_bits = busy ? {1'b0, byte_idx_q} + 4'h1 : 4'h0;

	// Control readback: written value plus live state
	logic [31:0] ctrl_rd;
	assign ctrl_rd = {23'h0, state_bits, ctrl_q.count, 1'b0, ctrl_q.en}; // RULE5 RULE6

	// Read mux; key registers read as zero
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;
	assign rd_mux = hit_ctrl ? ctrl_rd :
		hit_dat[0] ? {16'h0, dat_q[0]} :
		hit_dat[1] ? {16'h0, dat_q[1]} :
		hit_dat[2] ? {16'h0, dat_q[2]} :
		hit_baud_reload ? {16'h0, baud_q.reload} :
		hit_baud_config ? {31'h0, baud_q.en} : 32'h0;

	// Captured in the setup cycle, so read data stands steady for the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (psel & ~penable) begin
			prdata_q <= rd_mux;
		end
	end
	assign prdata = prdata_q;

	assign serial_test_port = line_q;

	// ----------------------------------------------------------------
	// Baud timer
	// ----------------------------------------------------------------
	stt_baud_timer u_baud_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(baud_q),
		.tick(baud_tick)
	);

	// Baud timer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_q <= '{en: 1'b0, reload: STT_RELOAD_RESET};
		end else begin
			if (wr_en & hit_baud_reload) begin
				baud_q.reload <= pwdata[15:0]; // RULE2
			end
			if (wr_en & hit_baud_config) begin
				baud_q.en <= pwdata[STT_BAUD_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Key sequence
	// ----------------------------------------------------------------
	// Any other mapped write breaks the sequence; reads and unmapped writes leave it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_q <= KEY_IDLE;
			held_q <= '0;
			held_q_rst_q <= 1'b0;
		end else if (wr_en) begin
			unique case (key_q)
				KEY_IDLE: begin
					key_q <= key_first_ok ? KEY_ARMED : KEY_IDLE;
				end
				KEY_ARMED: begin
					if (hit_ctrl) begin // RULE3
						key_q <= KEY_HELD;
						held_q.en <= pwdata[STT_CTRL_EN_BIT];
						held_q.count <= pwdata[STT_CTRL_CNT_MSB:STT_CTRL_CNT_LSB];
						held_q_rst_q <= pwdata[STT_CTRL_RST_BIT];
					end else begin
						key_q <= key_first_ok ? KEY_ARMED : KEY_IDLE;
					end
				end
				KEY_HELD: begin
					key_q <= (~key_second_ok & key_first_ok) ? KEY_ARMED : KEY_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control and data registers
	// ----------------------------------------------------------------
	// Load flags clear on every commit and at the end of a burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
			loaded_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				dat_q[i] <= STT_DATA_RESET;
			end
		end else if (commit_reset) begin
			ctrl_q <= '0; // RULE11
			loaded_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				dat_q[i] <= STT_DATA_RESET;
			end
		end else begin
			if (commit) begin
				ctrl_q <= held_q; // RULE3 RULE7
			end
			for (int i = 0; i < 3; i++) begin
				if (wr_en & hit_dat[i]) begin
					dat_q[i] <= pwdata[15:0];
				end
			end
			// A data write in the very cycle the burst ends still counts
			loaded_q <= (burst_end ? 3'h0 : loaded_q) | (hit_dat & {3{wr_en}}); // RULE4
		end
	end

	// ----------------------------------------------------------------
	// Transmit sequencer
	// ----------------------------------------------------------------
	// Start aligns to a timer tick so the first bit is a full period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= TX_IDLE;
			byte_idx_q <= 3'h0;
			bit_idx_q <= STT_BIT_START;
			line_q <= STT_LINE_IDLE;
		end else if (commit_reset | ~ctrl_q.en) begin
			tx_q <= TX_IDLE; // RULE7 RULE11
			byte_idx_q <= 3'h0;
			bit_idx_q <= STT_BIT_START;
			line_q <= STT_LINE_IDLE; // RULE13
		end else begin
			unique case (tx_q)
				TX_IDLE: begin
					if (data_ready & ~commit) begin // RULE1 RULE4
						tx_q <= TX_WAIT;
						byte_idx_q <= 3'h0;
					end
				end
				TX_WAIT: begin
					if (baud_tick) begin // RULE2
						tx_q <= TX_SEND;
						bit_idx_q <= STT_BIT_START;
						line_q <= STT_LINE_START; // RULE8
					end
				end
				TX_SEND: begin
					if (baud_tick) begin // RULE2
						if (bit_idx_q != STT_BIT_LAST) begin
							bit_idx_q <= next_bit;
							line_q <= next_line; // RULE8 RULE13
						end else if (last_byte) begin
							tx_q <= TX_IDLE; // RULE6
							byte_idx_q <= 3'h0;
							line_q <= STT_LINE_IDLE;
						end else begin
							byte_idx_q <= byte_idx_q + 3'h1;
							bit_idx_q <= STT_BIT_START;
							line_q <= STT_LINE_START;
						end
					end
				end
				default: begin
					tx_q <= TX_IDLE;
				end
			endcase
		end
	end

endmodule

// file: sim/stt_rx_model.sv
`timescale 1ns/1ps
// ----
// Passive test receiver on the serial line
// ----
module stt_rx_model #(
	parameter int BIT = 8
) (
	input wire logic pclk,
	input wire logic line
);
	logic [7:0] got [0:63];
	logic [11:0] fr;
	int n_rx = 0;
	int n_bad = 0;

	// Mid-bit sampling on the falling clock edge keeps clear of the launch edge
	initial forever begin
		@(negedge line);
		repeat (BIT / 2) @(negedge pclk);
		for (int i = 0; i < 12; i++) begin
			fr[i] = line;
			if (i < 11) repeat (BIT) @(negedge pclk);
		end
		// Start low, even parity, both stops high
		if (fr[0] !== 1'b0 || fr[9] !== ^fr[8:1] || fr[11:10] !== 2'b11) n_bad++;
		got[n_rx] = fr[8:1];
		n_rx++;
	end
endmodule

// file: sim/stt_serial_test_tx_properties.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module stt_tx_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_test_port
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access decode
	wire acc = psel && penable;
	wire mapped = paddr <= 8'h1c && paddr[1:0] == 2'b00;
	wire rd_ctrl = acc && !pwrite && paddr == 8'h00;

	ready_always_a: assert property (pready) else $error("pready low");
	err_unmapped_a: assert property (acc |-> pslverr == !mapped) else $error("bad pslverr");
	err_quiet_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
	key_read_zero_a: assert property (acc && !pwrite && (paddr == 8'h04 || paddr == 8'h08)
		|-> prdata == 32'h0) else $error("key reads nonzero");
	ctrl_rsv_zero_a: assert property (rd_ctrl |-> prdata[31:9] == 0 && !prdata[1])
		else $error("control reserved bits set");
	low_line_busy_a: assert property (rd_ctrl && !serial_test_port |-> prdata[8:5] != 0)
		else $error("busy line with zero state");
	off_line_idle_a: assert property (rd_ctrl && !prdata[0] |-> serial_test_port)
		else $error("line active while disabled");
	data_upper_zero_a: assert property (acc && !pwrite && paddr inside {8'h0c, 8'h10, 8'h14}
		|-> prdata[31:16] == 0) else $error("data upper bits set");
endmodule

bind stt_serial_test_tx stt_tx_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .serial_test_port(serial_test_port));

// file: sim/stt_serial_test_tx_bench.sv
`timescale 1ns/1ps
module stt_serial_test_tx_bench;
	import stt_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic serial_test_port;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	int n_mismatch = 0, total_checks = 0;

	// ----
	// Clock, design, receiver
	// ----
	always #2.5 pclk = ~pclk;
	stt_serial_test_tx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_test_port(serial_test_port));
	stt_rx_model #(.BIT(8)) rx (.pclk(pclk), .line(serial_test_port));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; idle cycle after so strobes never toggle twice in a step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic commit(input logic [31:0] v);
		apb(STT_OFS_KEY_FIRST, 1, 32'h7);
		apb(STT_OFS_CTRL, 1, v);
		apb(STT_OFS_KEY_SECOND, 1, 32'hb9);
	endtask
	task automatic done(input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(STT_OFS_CTRL, 0, 0);
			n++;
		end while (r !== v && n < 2000);
		chk(r, v);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic s_regs;
		logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
		foreach (a[i]) begin
			apb(a[i], 0, 0);
			chk(r, 32'h0);
			chk(32'(e), 32'h0);
		end
		apb(8'h20, 0, 0);
		chk(e, 1);
	endtask
	task automatic s_keys;
		apb(STT_OFS_CTRL, 1, 32'h5);
		apb(STT_OFS_CTRL, 0, 0);
		chk(r, 0);
		apb(STT_OFS_KEY_FIRST, 1, 32'h7);
		apb(STT_OFS_CTRL, 1, 32'h5);
		apb(STT_OFS_KEY_SECOND, 1, 32'h55);
		apb(STT_OFS_CTRL, 0, 0);
		chk(r, 0);
	endtask
	// Keyed and loaded, but no byte may leave until the timer runs
	task automatic s_timer;
		apb(STT_OFS_BAUD_RELOAD, 1, 32'h8);
		commit(32'h1);
		apb(STT_OFS_DAT_ONE_TWO, 1, 32'ha5);
		repeat (100) @(posedge pclk);
		chk(rx.n_rx, 0);
		apb(STT_OFS_BAUD_CONFIG, 1, 32'h1);
		done(32'h1);
		chk(rx.n_bad, 0);
		chk(32'(rx.got[0]), 32'ha5);
	endtask
	task automatic s_burst(input logic [2:0] c);
		logic [7:0] b [6];
		int base;
		base = rx.n_rx;
		foreach (b[i]) b[i] = {c, 5'(i * 3 + 1)};
		commit({27'h0, c, 2'b01});
		apb(STT_OFS_DAT_ONE_TWO, 1, {16'h0, b[1], b[0]});
		if (c > 1) apb(STT_OFS_DAT_THREE_FOUR, 1, {16'h0, b[3], b[2]});
		// Five bytes chosen, four loaded: line must stay quiet
		if (c == 3'h4) begin
			repeat (300) @(posedge pclk);
			chk(rx.n_rx, base);
		end
		if (c > 3) apb(STT_OFS_DAT_FIVE_SIX, 1, {16'h0, b[5], b[4]});
		apb(STT_OFS_CTRL, 0, 0);
		chk(r === {27'h0, c, 2'b01}, 0);
		done({27'h0, c, 2'b01});
		chk(rx.n_rx, base + c + 1);
		for (int i = 0; i <= c; i++) chk(rx.got[base + i], b[i]);
		chk(rx.n_bad, 0);
	endtask
	task automatic s_off;
		commit(32'h15);
		apb(STT_OFS_DAT_ONE_TWO, 1, 32'h0f0f);
		apb(STT_OFS_DAT_THREE_FOUR, 1, 32'h0f0f);
		apb(STT_OFS_DAT_FIVE_SIX, 1, 32'h0f0f);
		repeat (30) @(posedge pclk);
		commit(32'h14);
		apb(STT_OFS_CTRL, 0, 0);
		chk(r, 32'h14);
		chk(32'(serial_test_port), 32'h1);
		apb(STT_OFS_DAT_ONE_TWO, 1, 32'h1234);
		commit(32'h2);
		apb(STT_OFS_CTRL, 0, 0);
		chk(r, 0);
		apb(STT_OFS_DAT_ONE_TWO, 0, 0);
		chk(r, 0);
	endtask

	task automatic report_and_stop;
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_regs;
		s_keys;
		s_timer;
		for (int c = 0; c < 6; c++) s_burst(3'(c));
		s_off;
		report_and_stop;
	end
	// Whole run needs a few thousand cycles; generous margin
	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		report_and_stop;
	end
endmodule
